// ### cfdec_pkg.sv
// Constants and types for the configuration byte decoder
package cfdec_pkg;

  // Clock rate
  localparam int CLK_PERIOD_NS = 10;

  // Configuration space addresses
  localparam logic [21:0] CFG_ADDR_CORE_OSC_SLEEP  = 22'h300000;
  localparam logic [21:0] CFG_ADDR_OSC_SELECT      = 22'h300001;
  localparam logic [21:0] CFG_ADDR_BROWNOUT_PWRUP  = 22'h300002;
  localparam logic [21:0] CFG_ADDR_WATCHDOG        = 22'h300003;

  // Implemented bits of each byte
  localparam logic [7:0] MASK_CORE_OSC_SLEEP = 8'h5d;
  localparam logic [7:0] MASK_OSC_SELECT     = 8'hdf;
  localparam logic [7:0] MASK_BROWNOUT_PWRUP = 8'h7f;
  localparam logic [7:0] MASK_WATCHDOG       = 8'h7f;

  // Field positions
  localparam int EXT_INSTR_BIT  = 6;
  localparam int SOSC_LSB       = 3;
  localparam int LFOSC_PWR_BIT  = 2;
  localparam int REG_SRC_BIT    = 0;
  localparam int TWO_SPEED_BIT  = 7;
  localparam int CLK_MON_BIT    = 6;
  localparam int PLL_CFG_BIT    = 4;
  localparam int OSC_SEL_LSB    = 0;
  localparam int BOR_PWR_LSB    = 5;
  localparam int BOR_V_LSB      = 3;
  localparam int BOR_EN_LSB     = 1;
  localparam int PWRUP_N_BIT    = 0;
  localparam int WDT_PS_LSB     = 2;
  localparam int WDT_EN_LSB     = 0;

  // Secondary oscillator and two-bit mode codes
  localparam logic [1:0] SOSC_HIGH    = 2'h3;
  localparam logic [1:0] SOSC_DIGITAL = 2'h2;
  localparam logic [1:0] SOSC_LOW     = 2'h1;
  localparam logic [1:0] MODE_ALWAYS  = 2'h3;
  localparam logic [1:0] MODE_HI      = 2'h2;
  localparam logic [1:0] MODE_LO      = 2'h1;
  localparam logic [1:0] BOR_PWR_ZERO = 2'h3;

  // Power levels reported for the primary oscillator
  localparam logic [1:0] PWR_NONE = 2'h0;
  localparam logic [1:0] PWR_LOW  = 2'h1;
  localparam logic [1:0] PWR_MED  = 2'h2;
  localparam logic [1:0] PWR_HIGH = 2'h3;

  // Brown-out thresholds in millivolts
  localparam logic [11:0] BOR_MV_1V8 = 12'h708;
  localparam logic [11:0] BOR_MV_2V0 = 12'h7d0;
  localparam logic [11:0] BOR_MV_2V7 = 12'ha8c;
  localparam logic [11:0] BOR_MV_3V0 = 12'hbb8;

  // Watchdog base period and largest postscale code
  localparam int WDT_BASE_MS = 4;
  localparam int WDT_BASE_CYC = WDT_BASE_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [4:0] WDT_PS_MAX = 5'h14;

  // Primary oscillator families
  typedef enum logic [2:0] {
    OSC_LP, OSC_XT, OSC_HS, OSC_EXT_RC, OSC_INT_RC, OSC_EXT_CLK
  } cfdec_osc_kind_t;

endpackage

// ### cfdec_top.sv
// Configuration byte store access and decode into static controls
// Notes on behaviour
// - Extended instruction bit enables set extension
// - Secondary oscillator two-bit mode decode
// - Low-frequency oscillator sleep power select
// - Sleep regulator follows chosen runtime bit
// - Two-speed start-up enable bit
// - Fail-safe clock monitor enable bit
// - Config PLL bit enables the PLL, ORed with runtime bit
// - Internal oscillator PLL only by runtime bit
// - External clock codes, power and clock out
// - Remaining oscillator codes decode
// - Brown-out power level or zero-power detector
// - Brown-out trip voltage select
// - Brown-out enable mode with software bit
// - Power-up timer enable is active low
// - Power-up timer independent of brown-out
// - Watchdog postscale ratio, codes above reserved
// - Watchdog enable mode with software bit
// - Unimplemented bits read as zero
// - Bytes reached only by table operations
`timescale 1ns/10ps

module cfdec_top
  import cfdec_pkg::*;
#(
  parameter int WDT_BASE_CYCLES = cfdec_pkg::WDT_BASE_CYC
) (
  input  wire logic                        clk_i,
  input  wire logic                        rstn_i,
  input  wire logic [21:0]                 tbl_addr_i,
  input  wire logic                        tbl_rd_i,
  input  wire logic                        tbl_wr_i,
  input  wire logic [7:0]                  tbl_wdata_i,
  output logic      [7:0]                  tbl_rdata_o,
  output logic                             tbl_rvalid_o,
  input  wire logic [3:0][7:0]             nvm_bytes_i,
  output logic                             nvm_wr_o,
  output logic      [1:0]                  nvm_wr_idx_o,
  output logic      [7:0]                  nvm_wr_data_o,
  input  wire logic                        sleep_i,
  input  wire logic                        runtime_regulator_sleep_ctrl_i,
  input  wire logic                        runtime_retention_ctrl_i,
  input  wire logic                        runtime_pll_enable_i,
  input  wire logic                        software_brownout_enable_i,
  input  wire logic                        software_watchdog_enable_i,
  output logic                             cfg_valid_o,
  output logic                             ext_instr_enable_o,
  output logic                             sosc_high_power_o,
  output logic                             sosc_low_power_o,
  output logic                             secondary_clock_input_o,
  output logic                             sosc_reserved_o,
  output logic                             lf_osc_sleep_high_power_o,
  output logic                             sleep_regulator_ctrl_o,
  output logic                             ulp_regulator_enable_o,
  output logic                             two_speed_startup_enable_o,
  output logic                             clock_monitor_enable_o,
  output logic                             pll_active_o,
  output cfdec_pkg::cfdec_osc_kind_t       osc_kind_o,
  output logic      [1:0]                  osc_power_o,
  output logic                             osc_clkout_enable_o,
  output logic                             osc_code_invalid_o,
  output logic                             zero_power_brownout_detector_o,
  output logic      [1:0]                  brownout_power_level_o,
  output logic      [11:0]                 brownout_trip_mv_o,
  output logic                             brownout_active_o,
  output logic                             software_brownout_honored_o,
  output logic                             powerup_timer_enable_o,
  output logic      [4:0]                  watchdog_postscale_o,
  output logic                             watchdog_postscale_reserved_o,
  output logic      [39:0]                 watchdog_period_cycles_o,
  output logic                             watchdog_active_o,
  output logic                             software_watchdog_honored_o
);

  import cfdec_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic            loaded;
    logic [3:0][7:0] cfg;
    logic [7:0]      rdata;
    logic            rvalid;
    logic            nvm_wr;
    logic [1:0]      wr_idx;
    logic [7:0]      wr_data;
    logic            ext_instr;
    logic            sosc_hi;
    logic            sosc_lo;
    logic            sosc_dig;
    logic            sosc_rsvd;
    logic            lfosc_hi;
    logic            reg_ctrl;
    logic            ulp_reg;
    logic            two_speed;
    logic            clk_mon;
    logic            pll_act;
    cfdec_osc_kind_t osc_kind;
    logic [1:0]      osc_pwr;
    logic            clkout;
    logic            osc_inv;
    logic            zp_bor;
    logic [1:0]      bor_pwr;
    logic [11:0]     bor_mv;
    logic            bor_act;
    logic            bor_sw;
    logic            pwrup_en;
    logic [4:0]      wdt_ps;
    logic            wdt_rsvd;
    logic [39:0]     wdt_cyc;
    logic            wdt_act;
    logic            wdt_sw;
  } cfdec_state_t;

  cfdec_state_t st_r;
  cfdec_state_t st_nxt;

  // Implemented-bit mask of one byte
  function automatic logic [7:0] byte_mask(input logic [1:0] idx);
    logic [7:0] m;
    m = 8'h00;
    unique case (idx)
      2'h0: m = MASK_CORE_OSC_SLEEP;
      2'h1: m = MASK_OSC_SELECT;
      2'h2: m = MASK_BROWNOUT_PWRUP;
      2'h3: m = MASK_WATCHDOG;
    endcase
    return m;
  endfunction

  logic            tbl_hit;
  logic [1:0]      tbl_idx;
  logic [7:0]      b0;
  logic [7:0]      b1;
  logic [7:0]      b2;
  logic [7:0]      b3;
  logic [3:0]      osc_sel;
  logic [1:0]      bor_en;
  logic [1:0]      wdt_en;
  logic [1:0]      bor_v;

  // Table address decode over the four configuration bytes
  assign tbl_hit = (tbl_addr_i[21:2] == CFG_ADDR_CORE_OSC_SLEEP[21:2]);
  assign tbl_idx = tbl_addr_i[1:0];

  // Captured bytes and their fields
  assign b0     = st_r.cfg[0];
  assign b1     = st_r.cfg[1];
  assign b2     = st_r.cfg[2];
  assign b3     = st_r.cfg[3];
  assign osc_sel = b1[OSC_SEL_LSB+:4];
  assign bor_en = b2[BOR_EN_LSB+:2];
  assign bor_v  = b2[BOR_V_LSB+:2];
  assign wdt_en = b3[WDT_EN_LSB+:2];

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.nvm_wr = 1'b0;

    // One capture after reset release, then held
    if (!st_r.loaded) begin
      for (int i = 0; i < 4; i++) begin
        st_nxt.cfg[i] = nvm_bytes_i[i] & byte_mask(2'(i));
      end
      st_nxt.loaded = 1'b1;
    end

    // Table read of the live cells; outside the space reads zero
    if (tbl_rd_i) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = tbl_hit ? (nvm_bytes_i[tbl_idx] & byte_mask(tbl_idx))
                              : 8'h00;
    end

    // Table write forwarded to the cell array, one byte at a time
    if (tbl_wr_i && tbl_hit) begin
      st_nxt.nvm_wr  = 1'b1;
      st_nxt.wr_idx  = tbl_idx;
      st_nxt.wr_data = tbl_wdata_i & byte_mask(tbl_idx);
    end

    // Core and sleep controls
    st_nxt.ext_instr = b0[EXT_INSTR_BIT];
    st_nxt.sosc_hi   = b0[SOSC_LSB+:2] == SOSC_HIGH;
    st_nxt.sosc_dig  = b0[SOSC_LSB+:2] == SOSC_DIGITAL;
    st_nxt.sosc_lo   = b0[SOSC_LSB+:2] == SOSC_LOW;
    st_nxt.sosc_rsvd = b0[SOSC_LSB+:2] == 2'h0;
    st_nxt.lfosc_hi  = b0[LFOSC_PWR_BIT];

    // Sleep regulator source
    st_nxt.ulp_reg  = !b0[REG_SRC_BIT];
    st_nxt.reg_ctrl = b0[REG_SRC_BIT] ? runtime_regulator_sleep_ctrl_i
                                      : runtime_retention_ctrl_i;

    // Clock start-up and monitor
    st_nxt.two_speed = b1[TWO_SPEED_BIT];
    st_nxt.clk_mon   = b1[CLK_MON_BIT];

    // Primary oscillator code
    st_nxt.osc_inv = 1'b0;
    st_nxt.clkout  = 1'b0;
    st_nxt.osc_pwr = PWR_NONE;
    unique case (osc_sel)
      4'hd, 4'hc: begin
        st_nxt.osc_kind = OSC_EXT_CLK;
        st_nxt.osc_pwr  = PWR_LOW;
        st_nxt.clkout   = !osc_sel[0];
      end
      4'hb, 4'ha: begin
        st_nxt.osc_kind = OSC_EXT_CLK;
        st_nxt.osc_pwr  = PWR_MED;
        st_nxt.clkout   = !osc_sel[0];
      end
      4'h5, 4'h4: begin
        st_nxt.osc_kind = OSC_EXT_CLK;
        st_nxt.osc_pwr  = PWR_HIGH;
        st_nxt.clkout   = !osc_sel[0];
      end
      4'h9: begin
        st_nxt.osc_kind = OSC_INT_RC;
        st_nxt.clkout   = 1'b1;
      end
      4'h8: st_nxt.osc_kind = OSC_INT_RC;
      4'h7: st_nxt.osc_kind = OSC_EXT_RC;
      4'h6: begin
        st_nxt.osc_kind = OSC_EXT_RC;
        st_nxt.clkout   = 1'b1;
      end
      4'h3: begin
        st_nxt.osc_kind = OSC_HS;
        st_nxt.osc_pwr  = PWR_MED;
      end
      4'h2: begin
        st_nxt.osc_kind = OSC_HS;
        st_nxt.osc_pwr  = PWR_HIGH;
      end
      4'h1: st_nxt.osc_kind = OSC_XT;
      4'h0: st_nxt.osc_kind = OSC_LP;
      default: begin // Undefined codes fall back to LP crystal
        st_nxt.osc_kind = OSC_LP;
        st_nxt.osc_inv  = 1'b1;
      end
    endcase

    // PLL: config bit counts only outside internal RC modes
    if (osc_sel == 4'h9 || osc_sel == 4'h8) begin
      st_nxt.pll_act = runtime_pll_enable_i;
    end else begin
      st_nxt.pll_act = runtime_pll_enable_i | b1[PLL_CFG_BIT];
    end

    // Brown-out detector selection and threshold
    st_nxt.zp_bor  = b2[BOR_PWR_LSB+:2] == BOR_PWR_ZERO;
    st_nxt.bor_pwr = b2[BOR_PWR_LSB+:2];
    unique case (bor_v)
      2'h3: st_nxt.bor_mv = BOR_MV_1V8;
      2'h2: st_nxt.bor_mv = BOR_MV_2V0;
      2'h1: st_nxt.bor_mv = BOR_MV_2V7;
      2'h0: st_nxt.bor_mv = BOR_MV_3V0;
    endcase

    // Brown-out enable mode
    st_nxt.bor_sw = bor_en == MODE_LO;
    unique case (bor_en)
      MODE_ALWAYS: st_nxt.bor_act = 1'b1;
      MODE_HI:     st_nxt.bor_act = !sleep_i;
      MODE_LO:     st_nxt.bor_act = software_brownout_enable_i;
      2'h0:        st_nxt.bor_act = 1'b0;
    endcase

    // Power-up timer from its own bit alone
    st_nxt.pwrup_en = !b2[PWRUP_N_BIT];

    // Watchdog postscale and period
    st_nxt.wdt_ps   = b3[WDT_PS_LSB+:5];
    st_nxt.wdt_rsvd = b3[WDT_PS_LSB+:5] > WDT_PS_MAX;
    st_nxt.wdt_cyc  = st_nxt.wdt_rsvd ? 40'h0
                    : (40'(WDT_BASE_CYCLES) << b3[WDT_PS_LSB+:5]);

    // Watchdog enable mode
    st_nxt.wdt_sw = wdt_en == MODE_HI;
    unique case (wdt_en)
      MODE_ALWAYS: st_nxt.wdt_act = 1'b1;
      MODE_HI:     st_nxt.wdt_act = software_watchdog_enable_i;
      MODE_LO:     st_nxt.wdt_act = !sleep_i;
      2'h0:        st_nxt.wdt_act = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // Table port and cell write strobe
  assign tbl_rdata_o   = st_r.rdata;
  assign tbl_rvalid_o  = st_r.rvalid;
  assign nvm_wr_o      = st_r.nvm_wr;
  assign nvm_wr_idx_o  = st_r.wr_idx;
  assign nvm_wr_data_o = st_r.wr_data;

  // Core, oscillator and regulator controls
  assign cfg_valid_o                = st_r.loaded;
  assign ext_instr_enable_o         = st_r.ext_instr;
  assign sosc_high_power_o          = st_r.sosc_hi;
  assign sosc_low_power_o           = st_r.sosc_lo;
  assign secondary_clock_input_o    = st_r.sosc_dig;
  assign sosc_reserved_o            = st_r.sosc_rsvd;
  assign lf_osc_sleep_high_power_o  = st_r.lfosc_hi;
  assign sleep_regulator_ctrl_o     = st_r.reg_ctrl;
  assign ulp_regulator_enable_o     = st_r.ulp_reg;
  assign two_speed_startup_enable_o = st_r.two_speed;
  assign clock_monitor_enable_o     = st_r.clk_mon;
  assign pll_active_o               = st_r.pll_act;
  assign osc_kind_o                 = st_r.osc_kind;
  assign osc_power_o                = st_r.osc_pwr;
  assign osc_clkout_enable_o        = st_r.clkout;
  assign osc_code_invalid_o         = st_r.osc_inv;

  // Reset and watchdog controls
  assign zero_power_brownout_detector_o = st_r.zp_bor;
  assign brownout_power_level_o         = st_r.bor_pwr;
  assign brownout_trip_mv_o             = st_r.bor_mv;
  assign brownout_active_o              = st_r.bor_act;
  assign software_brownout_honored_o    = st_r.bor_sw;
  assign powerup_timer_enable_o         = st_r.pwrup_en;
  assign watchdog_postscale_o           = st_r.wdt_ps;
  assign watchdog_postscale_reserved_o  = st_r.wdt_rsvd;
  assign watchdog_period_cycles_o       = st_r.wdt_cyc;
  assign watchdog_active_o              = st_r.wdt_act;
  assign software_watchdog_honored_o    = st_r.wdt_sw;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  chk_capture_held: assert property (
    st_r.loaded |=> $stable(st_r.cfg) && st_r.loaded)
    else $error("captured bytes changed after load");

  chk_ext_instr: assert property (
    st_r.loaded |=> ext_instr_enable_o == $past(st_r.cfg[0][EXT_INSTR_BIT]))
    else $error("extended instruction output mismatch");

  chk_sosc_digital: assert property (
    st_r.loaded && b0[SOSC_LSB+:2] == SOSC_DIGITAL
    |=> secondary_clock_input_o && !sosc_high_power_o && !sosc_low_power_o)
    else $error("digital secondary clock mode not decoded");

  chk_reg_source: assert property (
    st_r.loaded |=> sleep_regulator_ctrl_o ==
      ($past(b0[REG_SRC_BIT]) ? $past(runtime_regulator_sleep_ctrl_i)
                              : $past(runtime_retention_ctrl_i)))
    else $error("sleep regulator source mismatch");

  chk_pll_intosc: assert property (
    st_r.loaded && (osc_sel == 4'h9 || osc_sel == 4'h8)
    |=> pll_active_o == $past(runtime_pll_enable_i))
    else $error("internal RC PLL not owned by runtime bit");

  chk_bor_mode: assert property (
    st_r.loaded && bor_en == MODE_HI && sleep_i |=> !brownout_active_o)
    else $error("brown-out active in sleep for mode 10");

  chk_pwrup_low: assert property (
    st_r.loaded |=> powerup_timer_enable_o != $past(b2[PWRUP_N_BIT]))
    else $error("power-up timer polarity wrong");

  chk_wdt_mode: assert property (
    st_r.loaded && wdt_en != MODE_HI && $changed(software_watchdog_enable_i)
    |=> !software_watchdog_honored_o)
    else $error("software watchdog bit honoured outside mode 10");

  chk_wdt_rsvd: assert property (
    watchdog_postscale_reserved_o |-> watchdog_period_cycles_o == 40'h0
      && watchdog_postscale_o > WDT_PS_MAX)
    else $error("reserved postscale gives a period");

  chk_unimp_zero: assert property (
    tbl_rvalid_o |-> (tbl_rdata_o & ~byte_mask($past(tbl_idx))) == 8'h00)
    else $error("unimplemented bit read as one");

  chk_read_latency: assert property (
    tbl_rd_i |=> tbl_rvalid_o ##1 !tbl_rvalid_o || $past(tbl_rd_i))
    else $error("table read answer timing wrong");

  cov_load: cover property (!st_r.loaded ##1 st_r.loaded);
  cov_read_hit: cover property (tbl_rd_i && tbl_hit ##1 tbl_rvalid_o);
  cov_write: cover property (tbl_wr_i && tbl_hit ##1 nvm_wr_o);
  cov_wdt_sw: cover property (software_watchdog_honored_o && watchdog_active_o);

endmodule

// ### cfdec_top_tb_top.sv
// Self-checking bench for the configuration byte decoder
`timescale 1ns/10ps

// Compare one value, count it, report a mismatch
`define CHK(nm, exp, got) \
  begin \
    n_tests = n_tests + 1; \
    if ((got) !== (exp)) begin \
      errors = errors + 1; \
      $display("ERROR %s expected %0h seen %0h", nm, (exp), (got)); \
    end \
  end

module cfdec_top_tb_top;
  import cfdec_pkg::*;

  localparam int              BASE = 4;
  localparam logic [3:0][7:0] MSK  = {MASK_WATCHDOG, MASK_BROWNOUT_PWRUP,
                                      MASK_OSC_SELECT, MASK_CORE_OSC_SLEEP};

  logic                  clk_i, rstn_i, tbl_rd_i, tbl_wr_i, tbl_rvalid_o;
  logic [21:0]           tbl_addr_i;
  logic [7:0]            tbl_wdata_i, tbl_rdata_o, nvm_wr_data_o, w;
  logic [3:0][7:0]       nvm_bytes_i, cfg;
  logic [1:0]            nvm_wr_idx_o, osc_power_o, brownout_power_level_o, idx;
  logic                  nvm_wr_o, sleep_i, runtime_regulator_sleep_ctrl_i;
  logic                  runtime_retention_ctrl_i, runtime_pll_enable_i;
  logic                  software_brownout_enable_i, software_watchdog_enable_i;
  logic                  cfg_valid_o, ext_instr_enable_o, sosc_high_power_o;
  logic                  sosc_low_power_o, secondary_clock_input_o, sosc_reserved_o;
  logic                  lf_osc_sleep_high_power_o, sleep_regulator_ctrl_o;
  logic                  ulp_regulator_enable_o, two_speed_startup_enable_o;
  logic                  clock_monitor_enable_o, pll_active_o, osc_clkout_enable_o;
  logic                  osc_code_invalid_o, zero_power_brownout_detector_o;
  logic                  brownout_active_o, software_brownout_honored_o;
  logic                  powerup_timer_enable_o, watchdog_postscale_reserved_o;
  logic                  watchdog_active_o, software_watchdog_honored_o;
  cfdec_osc_kind_t       osc_kind_o;
  logic [11:0]           brownout_trip_mv_o;
  logic [4:0]            watchdog_postscale_o;
  logic [39:0]           watchdog_period_cycles_o;
  logic [31:0]           seed, r;
  int                    errors, n_tests, it, k, a;

  cfdec_top #(.WDT_BASE_CYCLES(BASE)) cfdec_top_i (.*);

  // Free-running 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Expected oscillator family of a selection code
  function automatic cfdec_osc_kind_t exp_kind(input logic [3:0] f);
    case (f)
      4'hd, 4'hc, 4'hb, 4'ha, 4'h5, 4'h4: exp_kind = OSC_EXT_CLK;
      4'h9, 4'h8: exp_kind = OSC_INT_RC;
      4'h7, 4'h6: exp_kind = OSC_EXT_RC;
      4'h3, 4'h2: exp_kind = OSC_HS;
      4'h1: exp_kind = OSC_XT;
      default: exp_kind = OSC_LP;
    endcase
  endfunction

  // Expected oscillator power level of a selection code
  function automatic logic [1:0] exp_pwr(input logic [3:0] f);
    case (f)
      4'hd, 4'hc: exp_pwr = 2'h1;
      4'hb, 4'ha, 4'h3: exp_pwr = 2'h2;
      4'h5, 4'h4, 4'h2: exp_pwr = 2'h3;
      default: exp_pwr = 2'h0;
    endcase
  endfunction

  // Expected trip threshold in millivolts
  function automatic logic [11:0] exp_trip(input logic [1:0] v);
    case (v)
      2'h3: exp_trip = 12'h708;
      2'h2: exp_trip = 12'h7d0;
      2'h1: exp_trip = 12'ha8c;
      default: exp_trip = 12'hbb8;
    endcase
  endfunction

  // Table address for step a; step 5 lies below the space
  function automatic logic [21:0] rd_addr(input int s);
    rd_addr = (s == 5) ? 22'h2fffff : 22'h300000 + 22'(s);
  endfunction

  // Check every decoded output against the captured bytes
  task automatic chk_dec(input logic [3:0][7:0] b);
    logic [3:0] f;
    logic [4:0] ps;
    logic [1:0] be;
    logic [1:0] we;
    f = b[1][3:0];
    ps = b[3][6:2];
    be = b[2][2:1];
    we = b[3][1:0];
    `CHK("ext_instr", b[0][6], ext_instr_enable_o)
    `CHK("sosc_mode", {b[0][4:3] == 2'h3, b[0][4:3] == 2'h2, b[0][4:3] == 2'h1,
         b[0][4:3] == 2'h0}, {sosc_high_power_o, secondary_clock_input_o,
         sosc_low_power_o, sosc_reserved_o})
    `CHK("lf_osc_pwr", b[0][2], lf_osc_sleep_high_power_o)
    `CHK("sleep_reg", b[0][0] ? runtime_regulator_sleep_ctrl_i : runtime_retention_ctrl_i,
         sleep_regulator_ctrl_o)
    `CHK("ulp_reg", ~b[0][0], ulp_regulator_enable_o)
    `CHK("two_speed", b[1][7], two_speed_startup_enable_o)
    `CHK("clk_mon", b[1][6], clock_monitor_enable_o)
    `CHK("pll", (f == 4'h9 || f == 4'h8) ? runtime_pll_enable_i :
         (runtime_pll_enable_i | b[1][4]), pll_active_o)
    `CHK("osc_kind", exp_kind(f), osc_kind_o)
    `CHK("osc_pwr", exp_pwr(f), osc_power_o)
    `CHK("clkout", f inside {4'hc, 4'ha, 4'h4, 4'h9, 4'h6}, osc_clkout_enable_o)
    `CHK("osc_inv", f inside {4'he, 4'hf}, osc_code_invalid_o)
    `CHK("zp_bor", b[2][6:5] == 2'h3, zero_power_brownout_detector_o)
    `CHK("bor_pwr", b[2][6:5], brownout_power_level_o)
    `CHK("bor_trip", exp_trip(b[2][4:3]), brownout_trip_mv_o)
    `CHK("bor_act", (be == 2'h3) ? 1'b1 : (be == 2'h2) ? ~sleep_i :
         (be == 2'h1) ? software_brownout_enable_i : 1'b0, brownout_active_o)
    `CHK("bor_sw", be == 2'h1, software_brownout_honored_o)
    `CHK("pwrup", ~b[2][0], powerup_timer_enable_o)
    `CHK("wdt_ps", ps, watchdog_postscale_o)
    `CHK("wdt_rsv", ps > 5'h14, watchdog_postscale_reserved_o)
    `CHK("wdt_per", (ps <= 5'h14) ? (40'(BASE) << ps) : 40'h0,
         watchdog_period_cycles_o)
    `CHK("wdt_act", (we == 2'h3) ? 1'b1 : (we == 2'h2) ? software_watchdog_enable_i :
         (we == 2'h1) ? ~sleep_i : 1'b0, watchdog_active_o)
    `CHK("wdt_sw", we == 2'h2, software_watchdog_honored_o)
  endtask

  // Verdict and end of run
  task automatic results;
    $display("Comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #300000;
    errors = errors + 1;
    results();
  end

  // Main sequence: corner and random configurations, each after a reset
  initial begin
    seed = 32'h6c026090;
    errors = 0;
    n_tests = 0;
    rstn_i = 1'b0;
    tbl_addr_i = 22'h0;
    tbl_rd_i = 1'b0;
    tbl_wr_i = 1'b0;
    tbl_wdata_i = 8'h00;
    nvm_bytes_i = '1;
    {sleep_i, runtime_regulator_sleep_ctrl_i, runtime_retention_ctrl_i} = 3'h0;
    {runtime_pll_enable_i, software_brownout_enable_i, software_watchdog_enable_i} = 3'h0;
    repeat (10) @(posedge clk_i);
    for (it = 0; it < 24; it++) begin
      cfg = $random(seed);
      if (it == 0) cfg = '1;
      if (it == 1) cfg = '0;
      if (it >= 2) begin
        cfg[1][3:0] = it[3:0];
        cfg[3][6:2] = it[4:0];
      end
      @(posedge clk_i);
      rstn_i <= 1'b0;
      nvm_bytes_i <= cfg;
      repeat (2) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      #1;
      `CHK("cfg_valid", 1'b1, cfg_valid_o)
      // Every sleep and software-enable pairing, other runtime bits random
      for (k = 0; k < 4; k++) begin
        @(posedge clk_i);
        r = $random(seed);
        sleep_i <= k[0];
        software_brownout_enable_i <= k[1];
        software_watchdog_enable_i <= ~k[1];
        runtime_regulator_sleep_ctrl_i <= r[0];
        runtime_retention_ctrl_i <= r[1];
        runtime_pll_enable_i <= r[2];
        repeat (2) @(posedge clk_i);
        #1;
        chk_dec(cfg);
      end
      // Back-to-back table reads, the last two outside the space
      @(posedge clk_i);
      tbl_rd_i <= 1'b1;
      tbl_addr_i <= rd_addr(0);
      for (a = 1; a <= 6; a++) begin
        @(posedge clk_i);
        tbl_addr_i <= rd_addr(a);
        if (a == 6) tbl_rd_i <= 1'b0;
        #1;
        `CHK("rvalid", 1'b1, tbl_rvalid_o)
        `CHK("rdata", (a <= 4) ? (cfg[a-1] & MSK[a-1]) : 8'h00, tbl_rdata_o)
      end
      @(posedge clk_i);
      #1;
      `CHK("rvalid_end", 1'b0, tbl_rvalid_o)
      // Write into the space, then one just past it, back to back
      r = $random(seed);
      w = r[7:0];
      idx = r[9:8];
      @(posedge clk_i);
      tbl_wr_i <= 1'b1;
      tbl_addr_i <= 22'h300000 + 22'(idx);
      tbl_wdata_i <= w;
      @(posedge clk_i);
      tbl_addr_i <= 22'h300004;
      #1;
      `CHK("nvm_wr", 1'b1, nvm_wr_o)
      `CHK("nvm_idx", idx, nvm_wr_idx_o)
      `CHK("nvm_data", w & MSK[idx], nvm_wr_data_o)
      @(posedge clk_i);
      tbl_wr_i <= 1'b0;
      nvm_bytes_i <= ~cfg;
      #1;
      `CHK("nvm_wr_out", 1'b0, nvm_wr_o)
      // Refused write outside the space leaves index and data standing
      `CHK("nvm_idx_hold", idx, nvm_wr_idx_o)
      `CHK("nvm_data_hold", w & MSK[idx], nvm_wr_data_o)
      // Decoded controls stay as captured despite writes and cell changes
      repeat (3) @(posedge clk_i);
      #1;
      chk_dec(cfg);
      $display("Configuration %0d done", it);
    end
    results();
  end

endmodule
